// File: design/pwrctl_top.sv
// Downstream port power control, over-current sensing and charging indication.
// Assumes pins are resolved outside from out/oe/pullup and sampled synchronously.
`timescale 1ns/1ps

module pwrctl_top #(
  parameter int NP = pwrctl_pkg::NUM_PORTS,
  parameter int SINGLE_CYC = pwrctl_pkg::OCS_SINGLE_CYC,
  parameter int WINDOW_CYC = pwrctl_pkg::OCS_DOUBLE_CYC,
  parameter int BLANK = pwrctl_pkg::BLANK_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input pwrctl_pkg::pwrctl_mode_type port_mode,
  input wire logic [NP-1:0] port_power_en,
  input wire logic [NP-1:0] port_ctl_pins_in,
  output logic [NP-1:0] port_ctl_pins_out,
  output logic [NP-1:0] port_ctl_pins_oe,
  output logic [NP-1:0] port_ctl_pins_pullup,
  input wire logic shared_power_pin_in,
  output logic shared_power_pin_out,
  output logic shared_power_pin_oe,
  output logic shared_power_pin_pullup,
  input wire logic [NP-1:0] oc_clear,
  output logic [NP-1:0] oc_status,
  input wire logic [1:0] charge_enable_strap,
  input wire logic [NP-1:0] charge_query,
  output logic [NP-1:0] charge_ack,
  output logic [NP-1:0] high_current_ind
);
  import pwrctl_pkg::*;

  localparam int NCH = NP + 1;

  pwrctl_chan_if #(.NCH(NCH), .NP(NP)) chan ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive.

  logic [NP-1:0] next_pins_oe;
  logic [NP-1:0] next_pins_pullup;
  logic next_shared_oe;
  logic next_shared_pullup;

  function automatic logic any_set(input logic [NP-1:0] v);
    any_set = |v;
  endfunction

  always_comb begin
    next_pins_oe = '1;
    next_pins_pullup = '0;
    next_shared_oe = 1'b1;
    next_shared_pullup = 1'b0;
    unique case (port_mode)
      PWRCTL_COMBINED: begin
        // Each port pin carries its own enable and sense. [RULE_03]
        next_pins_oe = ~port_power_en; // [RULE_04] [RULE_05]
        next_pins_pullup = port_power_en; // [RULE_04] [RULE_05]
      end
      PWRCTL_GANGED: begin
        // One shared pin switches and senses every port. [RULE_02]
        next_shared_oe = !any_set(port_power_en); // [RULE_04]
        next_shared_pullup = any_set(port_power_en); // [RULE_05]
      end
    endcase
  end

  // The driven level is always low, so the pins only ever sink current.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      port_ctl_pins_out <= '0;
      port_ctl_pins_oe <= '1;
      port_ctl_pins_pullup <= '0;
      shared_power_pin_out <= 1'b0;
      shared_power_pin_oe <= 1'b1;
      shared_power_pin_pullup <= 1'b0;
    end else begin
      port_ctl_pins_out <= '0; // [RULE_04]
      port_ctl_pins_oe <= next_pins_oe;
      port_ctl_pins_pullup <= next_pins_pullup;
      shared_power_pin_out <= 1'b0;
      shared_power_pin_oe <= next_shared_oe;
      shared_power_pin_pullup <= next_shared_pullup;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Over-current sensing. A channel is sensed only while its pull-up is on,
  // so a pin that the block itself pulls low never counts as a fault.

  // Mode selects which channels are live. [RULE_01]
  assign chan.ch_en = {shared_power_pin_pullup, port_ctl_pins_pullup}; // [RULE_06]
  assign chan.ch_pin = {shared_power_pin_in, port_ctl_pins_in};

  for (genvar g = 0; g < NCH; g++) begin : g_det
    pwrctl_oc_detect #(
      .IDX(g),
      .SINGLE_CYC(SINGLE_CYC),
      .WINDOW_CYC(WINDOW_CYC),
      .BLANK(BLANK)
    ) u_det (
      .clock(clock),
      .sys_rst(sys_rst),
      .chan(chan)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Over-current status. A new event wins over a clear in the same cycle.

  logic [NP-1:0] next_oc_status;
  logic [NP-1:0] oc_hits;

  always_comb begin
    oc_hits = chan.oc_event[NP-1:0];
    if (chan.oc_event[NP]) begin
      oc_hits = '1; // [RULE_02]
    end
    next_oc_status = (oc_status & ~oc_clear) | oc_hits; // [RULE_15]
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      oc_status <= '0;
    end else begin
      oc_status <= next_oc_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Battery charging: acknowledge only, no current is sourced here.

  pwrctl_strap u_strap (
    .clock(clock),
    .sys_rst(sys_rst),
    .strap_code(charge_enable_strap),
    .chan(chan)
  );

  logic [NP-1:0] next_charge_ack;
  logic [NP-1:0] next_hc_ind;

  always_comb begin
    next_charge_ack = '0;
    next_hc_ind = '0;
    if (chan.strap_valid) begin
      next_charge_ack = charge_query & chan.charge_mask; // [RULE_12] [RULE_14]
      next_hc_ind = chan.charge_mask; // [RULE_13]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      charge_ack <= '0;
      high_current_ind <= '0;
    end else begin
      charge_ack <= next_charge_ack;
      high_current_ind <= next_hc_ind;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_off_drive_low: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_04]
    (port_mode == PWRCTL_COMBINED && !port_power_en[0]) |=>
      (port_ctl_pins_oe[0] && !port_ctl_pins_out[0] && !port_ctl_pins_pullup[0]))
    else $error("disabled port pin not driven low");

  chk_on_open_drain: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_05]
    (port_mode == PWRCTL_COMBINED && port_power_en[0]) |=>
      (!port_ctl_pins_oe[0] && port_ctl_pins_pullup[0]))
    else $error("enabled port pin not open-drain");

  chk_ganged_shared: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_02]
    (port_mode == PWRCTL_GANGED && port_power_en != '0) |=>
      (shared_power_pin_pullup && !shared_power_pin_oe && port_ctl_pins_oe == '1))
    else $error("ganged mode not on the shared pin");

  chk_oc_latch: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_15]
    chan.oc_event[0] |=> oc_status[0])
    else $error("over-current event not latched");

  chk_oc_hold: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_15]
    (oc_status[1] && !oc_clear[1]) |=> oc_status[1])
    else $error("over-current flag dropped without clear");

  chk_ack_only_bc: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_12]
    charge_ack[0] |-> ($past(charge_query[0]) && chan.charge_mask[0]))
    else $error("charge query acknowledged on non-charging port");

  chk_hc_indicate: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_13]
    chan.strap_valid |=> (high_current_ind == chan.charge_mask))
    else $error("high current indication mismatch");

  chk_off_drive_low1: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_04]
    (port_mode == PWRCTL_COMBINED && !port_power_en[1]) |=>
      (port_ctl_pins_oe[1] && !port_ctl_pins_out[1] && !port_ctl_pins_pullup[1]))
    else $error("disabled port 2 pin not driven low");

  chk_on_open_drain1: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_05]
    (port_mode == PWRCTL_COMBINED && port_power_en[1]) |=>
      (!port_ctl_pins_oe[1] && port_ctl_pins_pullup[1]))
    else $error("enabled port 2 pin not open-drain");

  chk_combined_shared: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_03]
    (port_mode == PWRCTL_COMBINED) |=>
      (shared_power_pin_oe && !shared_power_pin_pullup))
    else $error("shared pin released in combined mode");

  chk_ganged_ports_low: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_02]
    (port_mode == PWRCTL_GANGED) |=>
      (port_ctl_pins_oe == '1 && port_ctl_pins_pullup == '0))
    else $error("port pins released in ganged mode");

  chk_gang_off: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_04]
    (port_mode == PWRCTL_GANGED && port_power_en == '0) |=>
      (shared_power_pin_oe && !shared_power_pin_pullup))
    else $error("shared pin not driven low with all ports off");

  chk_drive_level: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_04]
    (port_ctl_pins_out == '0 && !shared_power_pin_out))
    else $error("pin drive level not low");

  chk_oc_latch1: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_15]
    chan.oc_event[1] |=> oc_status[1])
    else $error("port 2 over-current event not latched");

  chk_oc_gang_all: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_02]
    chan.oc_event[NP] |=> (oc_status == '1))
    else $error("shared pin over-current not flagged on every port");

  chk_oc_hold0: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_15]
    (oc_status[0] && !oc_clear[0]) |=> oc_status[0])
    else $error("port 1 over-current flag dropped without clear");

  chk_oc_cleared: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_15]
    (oc_clear[0] && !chan.oc_event[0] && !chan.oc_event[NP]) |=> !oc_status[0])
    else $error("port 1 over-current flag not cleared");

  chk_ack_only_bc1: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_12]
    charge_ack[1] |-> ($past(charge_query[1]) && chan.charge_mask[1]))
    else $error("charge query acknowledged on non-charging port 2");

  chk_ack_follows: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_12]
    (chan.strap_valid && charge_query[0] && chan.charge_mask[0]) |=> charge_ack[0])
    else $error("charge query on charging port not acknowledged");

  chk_no_ack_early: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_14]
    !chan.strap_valid |=> (charge_ack == '0))
    else $error("charge query acknowledged before strap capture");

endmodule

// File: design/pwrctl_pkg.sv
// Constants, timing figures and strap codes for the downstream port power
// control and over-current sensing block.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
//
// Functional notes
// RULE_01: Two port control configurations exist, ganged and combined, chosen by configuration.
// RULE_02: Ganged configuration uses one shared pin for power and over-current of all ports.
// RULE_03: Combined configuration gives each port one pin for power enable and sense.
// RULE_04: Power off drives the port pin low and switches its pull-up off.
// RULE_05: Power on releases the driver and enables the pull-up, acting open-drain.
// RULE_06: While a port is enabled its pin level is sampled continuously.
// RULE_07: A low lasting the single-pulse assertion time flags over-current.
// RULE_08: Two separate low groups within a 20 ms rolling window flag over-current.
// RULE_09: Transient lows, such as during power-up, are filtered and not reported.
// RULE_10: With a poly fuse, same drive behaviour; a low from a blown fuse means over-current.
// RULE_11: With poly fuses, software sets the power-on-to-good descriptor fields to zero.
// RULE_12: Charging ports only acknowledge a charging query; no charging current is supplied.
// RULE_13: A high-current external supply is indicated per port on the port pins; here on separate high_current_ind outputs, from the strap mask.
// RULE_14: The charge strap selects charging ports; a 200 kOhm pull-up enables port 1 only.
// RULE_15: Over-current latches a per-port status flag held until the hub clears it.

package pwrctl_pkg;

  localparam int NUM_PORTS = 2;

  // Clock and timing figures, each in its own unit.
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int T_OCS_SINGLE_MS = 1;
  localparam int T_OCS_DOUBLE_MS = 20;
  localparam int T_BLANK_US = 100;

  // Derived cycle counts; the single time is a longest time and rounds down.
  localparam int OCS_SINGLE_CYC = T_OCS_SINGLE_MS * (CLK_FREQ_HZ / 1000);
  localparam int OCS_DOUBLE_CYC = T_OCS_DOUBLE_MS * (CLK_FREQ_HZ / 1000);
  // Scaled per microsecond first, so the product stays inside a 32-bit int.
  localparam int BLANK_CYC = T_BLANK_US * (CLK_FREQ_HZ / 1_000_000);

  // Decoded level of the charge enable strap resistor.
  localparam logic [1:0] STRAP_NONE = 2'h0;
  localparam logic [1:0] STRAP_PU_200K = 2'h1;
  localparam logic [1:0] STRAP_PU_OTHER = 2'h2;
  localparam logic [1:0] STRAP_PD = 2'h3;

  // Charge masks per strap code, bit 0 is port 1.
  localparam logic [NUM_PORTS-1:0] MASK_NONE = 2'h0;
  localparam logic [NUM_PORTS-1:0] MASK_PORT1 = 2'h1;
  localparam logic [NUM_PORTS-1:0] MASK_PORT2 = 2'h2;
  localparam logic [NUM_PORTS-1:0] MASK_ALL = 2'h3;

  typedef enum logic [0:0] {
    PWRCTL_COMBINED,
    PWRCTL_GANGED
  } pwrctl_mode_type;

endpackage

// File: design/pwrctl_chan_if.sv
// Carrier between the port control core and its detectors and strap capture.
// Channel NUM_PORTS is the shared ganged pin; lower channels are the port pins.
`timescale 1ns/1ps

interface pwrctl_chan_if #(
  parameter int NCH = 3,
  parameter int NP = 2
);
  logic [NCH-1:0] ch_en;
  logic [NCH-1:0] ch_pin;
  logic [NCH-1:0] oc_event;
  logic [NP-1:0] charge_mask;
  logic strap_valid;

  modport core (output ch_en, output ch_pin, input oc_event, input charge_mask,
    input strap_valid);
  modport det (input ch_en, input ch_pin, output oc_event);
  modport strap (output charge_mask, output strap_valid);
endinterface

// File: design/pwrctl_oc_detect.sv
// Over-current filter and detector for one sense channel.
// Assumes the pin input is synchronous to clock and ch_en is a registered level.
`timescale 1ns/1ps

module pwrctl_oc_detect
  import pwrctl_pkg::*;
#(
  parameter int IDX = 0,
  parameter int SINGLE_CYC = pwrctl_pkg::OCS_SINGLE_CYC,
  parameter int WINDOW_CYC = pwrctl_pkg::OCS_DOUBLE_CYC,
  parameter int BLANK = pwrctl_pkg::BLANK_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  pwrctl_chan_if.det chan
);
  localparam int CW = $clog2(WINDOW_CYC + SINGLE_CYC + BLANK + 2);

  logic en_q;
  logic low_q;
  logic [CW-1:0] blank_cnt;
  logic [CW-1:0] low_cnt;
  logic [CW-1:0] win_cnt;
  logic event_q;
  logic next_en_q;
  logic next_low_q;
  logic [CW-1:0] next_blank_cnt;
  logic [CW-1:0] next_low_cnt;
  logic [CW-1:0] next_win_cnt;
  logic next_event_q;
  logic active;
  logic low;
  logic group_start;

  assign chan.oc_event[IDX] = event_q;

  always_comb begin
    next_en_q = chan.ch_en[IDX];
    // Blanking hides the sag while the port supply ramps up. [RULE_09]
    // The blanking count loads one edge after enable, so that first cycle is masked too.
    active = chan.ch_en[IDX] && en_q && (blank_cnt == '0);
    low = active && !chan.ch_pin[IDX]; // [RULE_06] [RULE_10]
    group_start = low && !low_q;
    next_low_q = low;
    next_event_q = 1'b0;
    next_blank_cnt = blank_cnt;
    next_low_cnt = '0;
    next_win_cnt = '0;
    if (!chan.ch_en[IDX]) begin
      next_blank_cnt = '0;
    end else if (!en_q) begin
      next_blank_cnt = CW'(BLANK); // [RULE_09]
    end else if (blank_cnt != '0) begin
      next_blank_cnt = blank_cnt - 1'b1;
    end
    if (active) begin
      if (low) begin
        next_low_cnt = low_cnt + 1'b1;
      end
      if (win_cnt != '0) begin
        next_win_cnt = win_cnt - 1'b1;
      end
      if (group_start) begin
        if (win_cnt != '0) begin
          next_event_q = 1'b1; // [RULE_08]
        end else begin
          next_win_cnt = CW'(WINDOW_CYC - 1); // [RULE_08]
        end
      end
      if (low && (low_cnt == CW'(SINGLE_CYC - 1))) begin
        next_event_q = 1'b1; // [RULE_07]
      end
      // After a report the detector starts afresh, so a low that stays on gives another pulse every SINGLE_CYC cycles.
      if (next_event_q) begin
        next_low_cnt = '0;
        next_win_cnt = '0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      en_q <= 1'b0;
      low_q <= 1'b0;
      blank_cnt <= '0;
      low_cnt <= '0;
      win_cnt <= '0;
      event_q <= 1'b0;
    end else begin
      en_q <= next_en_q;
      low_q <= next_low_q;
      blank_cnt <= next_blank_cnt;
      low_cnt <= next_low_cnt;
      win_cnt <= next_win_cnt;
      event_q <= next_event_q;
    end
  end

  chk_blank_quiet: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_09]
    (chan.ch_en[IDX] && !en_q) |=> !event_q [*2])
    else $error("over-current reported during power-up blanking");

  chk_single_low: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_07]
    (active && low && low_cnt == CW'(SINGLE_CYC - 1)) |=> event_q)
    else $error("long low pulse not reported");

  chk_double_low: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_08]
    (group_start && win_cnt != '0) |=> event_q)
    else $error("second low group in window not reported");

  chk_idle_no_event: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_06]
    (!chan.ch_en[IDX] && !$past(chan.ch_en[IDX])) |=> !event_q)
    else $error("event from a disabled channel");
endmodule

// File: design/pwrctl_strap.sv
// Captures the charge enable strap once after reset and decodes the ports
// that support battery charging.
// Assumes the strap level is settled by the time reset is released.
`timescale 1ns/1ps

module pwrctl_strap
  import pwrctl_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [1:0] strap_code,
  pwrctl_chan_if.strap chan
);
  logic [NUM_PORTS-1:0] mask;
  logic valid;
  logic [NUM_PORTS-1:0] next_mask;
  logic next_valid;

  function automatic logic [NUM_PORTS-1:0] strap_decode(input logic [1:0] code);
    unique case (code)
      STRAP_NONE: strap_decode = MASK_NONE;
      STRAP_PU_200K: strap_decode = MASK_PORT1; // [RULE_14]
      STRAP_PU_OTHER: strap_decode = MASK_ALL;
      STRAP_PD: strap_decode = MASK_PORT2;
    endcase
  endfunction

  assign chan.charge_mask = mask;
  assign chan.strap_valid = valid;

  // The strap is sampled by a clocked process on the first edge after release.
  always_comb begin
    next_valid = 1'b1;
    next_mask = valid ? mask : strap_decode(strap_code); // [RULE_14]
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mask <= MASK_NONE;
      valid <= 1'b0;
    end else begin
      mask <= next_mask;
      valid <= next_valid;
    end
  end

  chk_strap_stable: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_14]
    valid |=> (mask == $past(mask)))
    else $error("charge mask changed after capture");
endmodule

// File: dv/pwrctl_switch_model.sv
// Behavioural external power switch seen through one port control pin.
// Assumes the bench raises fault to make the switch pull the pin low.
`timescale 1ns/1ps

module pwrctl_switch_model (
  input wire logic clock,
  input wire logic out,
  input wire logic oe,
  input wire logic pull_on,
  input wire logic fault,
  output logic pin
);
  logic alt = 1'b0;

  // An undriven pin without pull-up floats, so it never holds a clean level.
  always @(posedge clock) begin
    alt <= ~alt;
  end

  // The switch or a blown fuse pulls the open-drain line low.
  // The supply is good at once, as a fuse supply with a zero power-on-to-good time.
  assign pin = oe ? out : (pull_on ? ~fault : alt);
endmodule

// File: dv/test_pwrctl_top.sv
// Self-checking bench for the port power control block.
// Assumes reduced detector counts and one switch model per pin.
`timescale 1ns/1ps

module test_pwrctl_top;
  import pwrctl_pkg::*;
  localparam int SC = 20;
  localparam int WC = 100;
  localparam int BK = 5;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  pwrctl_mode_type port_mode = PWRCTL_COMBINED;
  logic [1:0] port_power_en = 2'h0;
  logic [1:0] oc_clear = 2'h0;
  logic [1:0] charge_query = 2'h0;
  logic [1:0] strap = 2'h1;
  logic [2:0] fault = 3'h0;
  logic [2:0] pin;
  logic [1:0] p_out, p_oe, p_pu, oc_status, charge_ack, hci;
  logic s_out, s_oe, s_pu;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;

  pwrctl_top #(.SINGLE_CYC(SC), .WINDOW_CYC(WC), .BLANK(BK)) dut (
    .clock(clock), .sys_rst(sys_rst), .port_mode(port_mode),
    .port_power_en(port_power_en), .port_ctl_pins_in(pin[1:0]),
    .port_ctl_pins_out(p_out), .port_ctl_pins_oe(p_oe), .port_ctl_pins_pullup(p_pu),
    .shared_power_pin_in(pin[2]), .shared_power_pin_out(s_out),
    .shared_power_pin_oe(s_oe), .shared_power_pin_pullup(s_pu),
    .oc_clear(oc_clear), .oc_status(oc_status), .charge_enable_strap(strap),
    .charge_query(charge_query), .charge_ack(charge_ack), .high_current_ind(hci));

  wire [2:0] all_out = {s_out, p_out};
  wire [2:0] all_oe = {s_oe, p_oe};
  wire [2:0] all_pu = {s_pu, p_pu};

  for (genvar i = 0; i < 3; i++) begin : g_sw
    pwrctl_switch_model sw (.clock(clock), .out(all_out[i]), .oe(all_oe[i]),
      .pull_on(all_pu[i]), .fault(fault[i]), .pin(pin[i]));
  end

  initial begin
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A hung wait still ends in the one closing report.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      close_out();
    end
  end

  task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic settle();
    @(negedge clock);
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    tick(16);
    sys_rst <= 1'b0;
    tick(3);
  endtask

  task automatic low(input int ch, input int n);
    fault[ch] <= 1'b1;
    tick(n);
    fault[ch] <= 1'b0;
    tick(1);
  endtask

  task automatic clear_oc();
    oc_clear <= 2'h3;
    tick(1);
    oc_clear <= 2'h0;
    tick(2);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    settle();
    check("oe", all_oe, 3'h7);
    check("out", all_out, 3'h0);
    check("pullup", all_pu, 3'h0);
    check("oc", {1'b0, oc_status}, 3'h0);
    tick(1);
  endtask

  // Enable with a power-up dip on port 2 that must be filtered out.
  task automatic t_power();
    port_power_en <= 2'h3;
    fault[1] <= 1'b1;
    settle();
    check("oe", all_oe, 3'h7);
    tick(1);
    settle();
    check("oe", all_oe, 3'h4);
    check("pullup", all_pu, 3'h3);
    tick(2);
    fault[1] <= 1'b0;
    tick(12);
    low(1, 3);
    tick(3);
    settle();
    check("oc", {1'b0, oc_status}, 3'h0);
    tick(1);
  endtask

  task automatic t_single();
    tick(WC + 10);
    low(0, SC - 2);
    tick(3);
    settle();
    check("oc", {1'b0, oc_status}, 3'h0);
    tick(WC + 10);
    low(0, SC + 3);
    tick(2);
    settle();
    check("oc", {1'b0, oc_status}, 3'h1);
    tick(20);
    settle();
    check("oc", {1'b0, oc_status}, 3'h1);
    tick(1);
    clear_oc();
    settle();
    check("oc", {1'b0, oc_status}, 3'h0);
    tick(1);
  endtask

  task automatic t_double();
    tick(WC + 10);
    low(1, 3);
    tick(10);
    low(1, 3);
    tick(3);
    settle();
    check("oc", {1'b0, oc_status}, 3'h2);
    tick(1);
    clear_oc();
    low(1, 3);
    tick(WC + 20);
    low(1, 3);
    tick(3);
    settle();
    check("oc", {1'b0, oc_status}, 3'h0);
    tick(WC + 10);
  endtask

  task automatic t_gang();
    port_mode <= PWRCTL_GANGED;
    port_power_en <= 2'h1;
    tick(2);
    settle();
    check("oe", all_oe, 3'h3);
    check("pullup", all_pu, 3'h4);
    tick(BK + 5);
    low(2, SC + 3);
    tick(2);
    settle();
    check("oc", {1'b0, oc_status}, 3'h3);
    tick(1);
    clear_oc();
    port_power_en <= 2'h0;
    tick(2);
    settle();
    check("oe", all_oe, 3'h7);
    check("pullup", all_pu, 3'h0);
    tick(1);
    port_mode <= PWRCTL_COMBINED;
  endtask

  // Strap code 1 is the 200 kOhm pull-up, charging on port 1 alone.
  task automatic t_charge();
    logic [1:0] mask [4];
    mask = '{2'h0, 2'h1, 2'h3, 2'h2};
    for (int c = 0; c < 4; c++) begin
      strap <= c[1:0];
      do_reset();
      settle();
      check("hci", {1'b0, hci}, {1'b0, mask[c]});
      tick(1);
      charge_query <= 2'h3;
      tick(1);
      settle();
      check("ack", {1'b0, charge_ack}, {1'b0, mask[c]});
      tick(1);
      charge_query <= 2'h0;
      tick(1);
      settle();
      check("ack", {1'b0, charge_ack}, 3'h0);
      tick(1);
    end
  endtask

  initial begin
    do_reset();
    t_reset();
    t_power();
    t_single();
    t_double();
    t_gang();
    t_charge();
    close_out();
  end
endmodule
